// >>> hw/scpm_defs.vh
// constants for the serial control port host master
`ifndef SCPM_DEFS_VH
`define SCPM_DEFS_VH
// command/address byte layout
`define SCPM_RW_BIT        7
`define SCPM_READ          1'b1
`define SCPM_WRITE         1'b0
`define SCPM_ADDR_W        7
// configuration register, its fields and the two indirect registers
`define SCPM_CFG_ADDR      7'h00
`define SCPM_CHAIN_BIT     7
`define SCPM_RELEASE_BIT   6
`define SCPM_IND_LO_ADDR   7'h1D
`define SCPM_IND_HI_ADDR   7'h1E
// serial clock timing: half period in ns, 100 MHz system clock
`define SCPM_CLK_NS        10
`define SCPM_HALF_NS       500
`define SCPM_HALF_CYC      ((`SCPM_HALF_NS + `SCPM_CLK_NS - 1) / `SCPM_CLK_NS)
// chip select high time between bytes, in half periods
`define SCPM_GAP_HALVES    2
`endif

// >>> hw/scpm_byte_shift.v
// one byte shifter: msb first, drive on fall, sample on rise
`timescale 1ns/100ps
module scpm_byte_shift #(
   parameter WIDTH = 8
) (
   // clock and reset
   input  wire             i_clock,
   input  wire             i_arst_n,
   // control
   input  wire             i_load,
   input  wire [WIDTH-1:0] i_data,
   input  wire             i_fall,
   input  wire             i_rise,
   input  wire             i_sdi,
   // results
   output reg              o_sdo,
   output reg  [WIDTH-1:0] o_rx
);
   reg [WIDTH-1:0] tx;

   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx    <= {WIDTH{1'b0}};
         o_sdo <= 1'b1;
         o_rx  <= {WIDTH{1'b0}};
      end else if (i_load) begin
         // first fall repeats the msb: no bit may leave before a rise
         tx    <= i_data;
         o_sdo <= i_data[WIDTH-1];
      end else begin
         if (i_fall) begin
            o_sdo <= tx[WIDTH-1];
            tx    <= {tx[WIDTH-2:0], 1'b0};
         end
         if (i_rise)
            o_rx <= {o_rx[WIDTH-2:0], i_sdi};
      end
   end
endmodule // scpm_byte_shift

// >>> hw/scpm_host.v
// host master for the device's four wire serial control port
`timescale 1ns/100ps
`include "scpm_defs.vh"
module scpm_host #(
   parameter HALF_CYC = `SCPM_HALF_CYC,
   parameter CHAIN_N  = 8
) (
   // clock and reset
   input  wire               i_clock,
   input  wire               i_arst_n,
   // user request
   input  wire               i_req,
   input  wire               i_read,
   input  wire [6:0]         i_addr,
   input  wire [7:0]         i_wdata,
   input  wire [CHAIN_N-1:0] i_chain_sel,
   output wire               o_ready,
   output reg                o_done,
   output reg  [7:0]         o_rdata,
   output reg                o_chain_mode_enable,
   // serial pins
   output reg                o_sclk,
   output reg                o_cs_n,
   output wire               o_sdi,
   output reg                o_sdi_oe,
   input  wire               i_sdo
);
   localparam ST_IDLE  = 3'd0;
   localparam ST_SETUP = 3'd1;
   localparam ST_SHIFT = 3'd2;
   localparam ST_HOLD  = 3'd3;
   localparam ST_GAP   = 3'd4;
   localparam ST_END   = 3'd5;
   localparam [3:0] GAP_LAST = `SCPM_GAP_HALVES - 1;

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [15:0] tick;
   reg  [3:0]  halves;
   reg  [1:0]  byte_idx;
   reg  [1:0]  last_idx;
   reg         rd;
   reg  [6:0]  addr;
   reg  [7:0]  wdata;
   reg  [7:0]  sel;
   reg         sdo_meta;
   reg         sdo_sync;
   reg         load;
   reg  [7:0]  load_data;
   wire        half_end;
   wire        hold_end;
   wire        fall;
   wire        rise;
   wire [7:0]  rx;

   assign half_end = (tick == HALF_CYC[15:0] - 16'h0001);
   assign fall     = (state == ST_SHIFT) && half_end && o_sclk;
   assign rise     = (state == ST_SHIFT) && half_end && !o_sclk;
   assign o_ready  = (state == ST_IDLE);
   assign hold_end = (state == ST_HOLD) && half_end;

   // device output passes two flops before the shifter samples it
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sdo_meta <= 1'b1;
         sdo_sync <= 1'b1;
      end else begin
         sdo_meta <= i_sdo;
         sdo_sync <= sdo_meta;
      end
   end

   scpm_byte_shift #(
      .WIDTH (8)
   ) u_shift (
      .i_clock  (i_clock),
      .i_arst_n (i_arst_n),
      .i_load   (load),
      .i_data   (load_data),
      .i_fall   (fall),
      .i_rise   (rise),
      .i_sdi    (sdo_sync),
      .o_sdo    (o_sdi),
      .o_rx     (rx)
   );

   // byte sequence: optional chain select, command, data
   always @* begin
      load_data = 8'h00;
      if (byte_idx == last_idx - 2'd1)
         load_data = {rd, addr};
      else if (byte_idx == last_idx)
         load_data = wdata;
      else
         load_data = sel;
   end

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (i_req)
               next_state = ST_SETUP;
         end
         ST_SETUP: begin
            if (half_end)
               next_state = ST_SHIFT;
         end
         ST_SHIFT: begin
            // sixteen halves leave the clock high again
            if (half_end && halves == 4'd15)
               next_state = ST_HOLD;
         end
         ST_HOLD: begin
            if (half_end && byte_idx == last_idx)
               next_state = ST_END;
            else if (half_end)
               next_state = ST_GAP;
         end
         ST_GAP: begin
            if (half_end && halves == GAP_LAST)
               next_state = ST_SETUP;
         end
         ST_END: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // state register
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // half period timer, restarted on every state change
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tick <= 16'h0000;
      end else if (state == ST_IDLE || next_state != state) begin
         tick <= 16'h0000;
      end else if (half_end) begin
         tick <= 16'h0000;
      end else begin
         tick <= tick + 16'h0001;
      end
   end

   // halves counted only while shifting or waiting between bytes
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         halves <= 4'h0;
      end else begin
         case (state)
            ST_SHIFT: begin
               if (half_end)
                  halves <= halves + 4'h1;
            end
            ST_GAP: begin
               if (half_end)
                  halves <= halves + 4'h1;
            end
            default: begin
               halves <= 4'h0;
            end
         endcase
      end
   end

   // request captured once; later i_req changes cannot disturb a frame
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd       <= 1'b0;
         addr     <= 7'h00;
         wdata    <= 8'h00;
         sel      <= 8'h00;
         last_idx <= 2'd1;
      end else if (state == ST_IDLE && i_req) begin
         rd               <= i_read;
         addr             <= i_addr;
         wdata            <= i_wdata;
         sel              <= 8'h00;
         sel[CHAIN_N-1:0] <= i_chain_sel;
         last_idx         <= o_chain_mode_enable ? 2'd2 : 2'd1;
      end
   end

   // byte index and shifter load pulse
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         byte_idx <= 2'd0;
         load     <= 1'b0;
      end else begin
         load <= 1'b0;
         if (state == ST_IDLE && i_req) begin
            byte_idx <= 2'd0;
            load     <= 1'b1;
         end else if (hold_end && byte_idx != last_idx) begin
            byte_idx <= byte_idx + 2'd1;
            load     <= 1'b1;
         end
      end
   end

   // serial clock, high whenever no byte is shifting
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sclk <= 1'b1;
      end else if (state == ST_IDLE) begin
         o_sclk <= 1'b1;
      end else if (state == ST_SHIFT && half_end) begin
         o_sclk <= ~o_sclk;
      end
   end

   // select falls one clock into setup, two half periods less one clock before the first fall
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cs_n <= 1'b1;
      end else if (state == ST_SETUP) begin
         o_cs_n <= 1'b0;
      end else if (hold_end) begin
         o_cs_n <= 1'b1;
      end
   end

   // release the shared wire for the read data byte
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sdi_oe <= 1'b0;
      end else if (state == ST_SETUP) begin
         o_sdi_oe <= !(rd && byte_idx == last_idx);
      end else if (hold_end) begin
         o_sdi_oe <= 1'b0;
      end
   end

   // completion pulse and read data
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_done  <= 1'b0;
         o_rdata <= 8'h00;
      end else begin
         o_done <= (state == ST_END);
         if (state == ST_END && rd) begin
            o_rdata <= rx;
         end
      end
   end

   // chain mode mirrors our own writes to register 0; a write that
   // reaches no device is still taken, a limitation of tracking it here
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_chain_mode_enable <= 1'b0;
      end else if (state == ST_END && !rd && addr == `SCPM_CFG_ADDR) begin
         o_chain_mode_enable <= wdata[`SCPM_CHAIN_BIT];
      end
   end
endmodule // scpm_host

// >>> verification/scpm_host_asserts.sv
// assertions on the serial control port host pins
`timescale 1ns/100ps
module scpm_host_asserts #(
   parameter HALF_CYC = 4
) (
   input wire logic i_clock, i_arst_n, i_req, o_ready, o_done,
   input wire logic o_sclk, o_cs_n, o_sdi, o_sdi_oe, o_chain_mode_enable
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   // bench build runs HALF_CYC at 4
   property p_half; $fell(o_sclk) |-> !o_sclk [*4] ##1 o_sclk; endproperty
   a_half: assert property (p_half) else $error("sclk half");
   property p_idle; o_cs_n |-> o_sclk; endproperty
   a_idle: assert property (p_idle) else $error("sclk idle");
   property p_stable;
      o_sclk && !o_cs_n && o_sdi_oe && $past(o_sclk && !o_cs_n)
         |-> $stable(o_sdi);
   endproperty
   a_stable: assert property (p_stable) else $error("sdi moved");
   property p_take; o_ready && i_req |-> ##[1:3] !o_cs_n; endproperty
   a_take: assert property (p_take) else $error("no frame");
   property p_gap; $rose(o_cs_n) |-> o_cs_n [*3]; endproperty
   a_gap: assert property (p_gap) else $error("cs gap");
   property p_done; o_done |-> o_cs_n && $past(o_cs_n) ##1 !o_done; endproperty
   a_done: assert property (p_done) else $error("done");
   property p_fall; $fell(o_sclk) |-> !o_cs_n && !$past(o_cs_n); endproperty
   a_fall: assert property (p_fall) else $error("cs late");
   property p_chain; $changed(o_chain_mode_enable) |-> o_cs_n; endproperty
   a_chain: assert property (p_chain) else $error("chain");
endmodule // scpm_host_asserts
bind scpm_host scpm_host_asserts #(.HALF_CYC(HALF_CYC)) i_chk (
   .i_clock(i_clock), .i_arst_n(i_arst_n), .i_req(i_req),
   .o_ready(o_ready), .o_done(o_done), .o_sclk(o_sclk), .o_cs_n(o_cs_n),
   .o_sdi(o_sdi), .o_sdi_oe(o_sdi_oe),
   .o_chain_mode_enable(o_chain_mode_enable));

// >>> verification/scpm_dev_model.sv
// behavioural device end of the serial control port
`timescale 1ns/100ps
module scpm_dev_model (
   input  wire i_sclk,
   input  wire i_cs_n,
   input  wire i_sdi,
   output reg  o_sdo,
   output reg  o_pass
);
   // direct registers only; indirect space is reached through them
   reg [7:0] rg [0:127];
   reg [7:0] sh, dat;
   reg [6:0] adr;
   reg [3:0] nb;
   reg [1:0] bi;
   reg       rd, sel;
   initial begin
      o_sdo = 1'b0;
      rg[0] = 8'h00;
      bi = 2'h0;
      nb = 4'h0;
   end
   always @(negedge i_cs_n) nb = 4'h0;
   // released output toggles: no pull on the wire
   always @(posedge i_cs_n) if (rg[0][6]) o_sdo = ~o_sdo;
   always @(negedge i_sclk) if (!i_cs_n) begin
      o_pass = sh[0];
      if (bi == 2'h2 && rd && sel && nb < 8)
         o_sdo = dat[7 - nb];
      else if (!rg[0][6])
         o_sdo = ~o_sdo;
   end
   always @(posedge i_sclk) if (!i_cs_n) begin
      sh = {sh[6:0], i_sdi};
      nb = nb + 4'h1;
      if (nb == 4'h8) begin
         if (bi == 2'h0 && rg[0][7]) begin
            sel = sh[0];
            bi = 2'h1;
         end else if (bi != 2'h2) begin
            if (bi == 2'h0) sel = 1'b1;
            rd = sh[7];
            adr = sh[6:0];
            dat = rg[sh[6:0]];
            bi = 2'h2;
         end else begin
            if (!rd && sel) rg[adr] = sh;
            bi = 2'h0;
         end
      end
   end
endmodule // scpm_dev_model

// >>> verification/tb_scpm_host.sv
// self checking bench for the serial control port host
`timescale 1ns/100ps
module tb_scpm_host;
   logic       i_clock, i_arst_n, i_req, i_read, dev_sdo;
   logic [6:0] i_addr;
   logic [7:0] i_wdata, i_chain_sel, o_rdata;
   logic       o_ready, o_done, o_chain_mode_enable;
   logic       o_sclk, o_cs_n, o_sdi, o_sdi_oe;
   int         num_errors = 0;
   int         checks_done = 0;
   scpm_host #(.HALF_CYC(4), .CHAIN_N(8)) i_scpm_host (.i_clock(i_clock),
      .i_arst_n(i_arst_n), .i_req(i_req), .i_read(i_read), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_chain_sel(i_chain_sel), .o_ready(o_ready),
      .o_done(o_done), .o_rdata(o_rdata),
      .o_chain_mode_enable(o_chain_mode_enable), .o_sclk(o_sclk),
      .o_cs_n(o_cs_n), .o_sdi(o_sdi), .o_sdi_oe(o_sdi_oe), .i_sdo(dev_sdo));
   // one shared data wire: device level shows once the host lets go
   scpm_dev_model i_scpm_dev_model (.i_sclk(o_sclk), .i_cs_n(o_cs_n),
      .i_sdi(o_sdi_oe ? o_sdi : dev_sdo), .o_sdo(dev_sdo), .o_pass());
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task acc(input logic r, input logic [6:0] a, input logic [7:0] d, s);
      int n;
      @(posedge i_clock);
      i_req <= 1'b1;
      i_read <= r;
      i_addr <= a;
      i_wdata <= d;
      i_chain_sel <= s;
      @(posedge i_clock);
      i_req <= 1'b0;
      n = 0;
      while (o_done !== 1'b1 && n < 2000) begin
         @(posedge i_clock);
         n++;
      end
      if (n == 2000) num_errors++;
   endtask
   task t_plain;
      acc(1'b0, 7'h05, 8'hA5, 8'h00);
      acc(1'b1, 7'h05, 8'h00, 8'h00);
      chk("rdata", 8'hA5, o_rdata);
      acc(1'b0, 7'h7F, 8'h3C, 8'h00);
      acc(1'b1, 7'h7F, 8'h00, 8'h00);
      chk("rdata", 8'h3C, o_rdata);
      $display("plain done");
   endtask
   task t_release;
      acc(1'b0, 7'h00, 8'h40, 8'h00);
      acc(1'b1, 7'h00, 8'h00, 8'h00);
      chk("cfg", 8'h40, o_rdata);
      acc(1'b1, 7'h05, 8'h00, 8'h00);
      chk("rdata", 8'hA5, o_rdata);
      acc(1'b0, 7'h00, 8'h00, 8'h00);
      $display("release done");
   endtask
   task t_chain;
      acc(1'b0, 7'h00, 8'h80, 8'h00);
      chk("chain", 8'h01, {7'h00, o_chain_mode_enable});
      acc(1'b0, 7'h05, 8'h11, 8'h01);
      acc(1'b0, 7'h05, 8'h22, 8'h02);
      acc(1'b1, 7'h05, 8'h00, 8'h01);
      chk("rdata", 8'h11, o_rdata);
      acc(1'b0, 7'h00, 8'h00, 8'h01);
      chk("chain", 8'h00, {7'h00, o_chain_mode_enable});
      $display("chain done");
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      i_arst_n = 1'b0;
      i_req = 1'b0;
      i_read = 1'b0;
      i_addr = 7'h00;
      i_wdata = 8'h00;
      i_chain_sel = 8'h00;
      repeat (3) @(posedge i_clock);
      i_arst_n <= 1'b1;
      t_plain;
      t_release;
      t_chain;
      tally_and_finish;
   end
   initial begin
      #100000;
      num_errors++;
      tally_and_finish;
   end
endmodule // tb_scpm_host
